// File: core/cmp_defs.svh
// Register offsets, field positions, reset values and arithmetic constants of the math block
`ifndef CMP_DEFS_SVH
`define CMP_DEFS_SVH

// Register byte offsets, one aligned 32-bit word each
`define CMP_REG_CTRL      8'h00
`define CMP_REG_SAMPLE    8'h04
`define CMP_REG_GAIN      8'h08
`define CMP_REG_ROT_D     8'h0c
`define CMP_REG_ROT_Q     8'h10
`define CMP_REG_THETA     8'h14
`define CMP_REG_PH_U      8'h18
`define CMP_REG_PH_V      8'h1c
`define CMP_REG_PH_W      8'h20
`define CMP_REG_CL_IN     8'h24
`define CMP_REG_CL_UP     8'h28
`define CMP_REG_CL_LO     8'h2c
`define CMP_REG_HP_OUT    8'h30
`define CMP_REG_ROT_OUT   8'h34
`define CMP_REG_CLK_OUT   8'h38
`define CMP_REG_CL_OUT    8'h3c
`define CMP_REG_STATUS    8'h40

// Field positions
`define CMP_CTRL_EN_BIT   0
`define CMP_STAT_BUSY_BIT 0
`define CMP_CL_UPPER_SATURATION_FLAG_BIT   16
`define CMP_CL_LOWER_SATURATION_FLAG_BIT   17

// Reset values
`define CMP_RST_W16       16'h0000
`define CMP_RST_W32       32'h0000_0000

// Arithmetic constants
`define CMP_HP_SHIFT      3
`define CMP_CLARK_GAIN    17'sh0093d
`define CMP_CLARK_SHIFT   11
`define CMP_ROT_ITERS     14
`define CMP_THETA_SHIFT   4
`define CMP_HALF_TURN     16'h8000

// Sample FIFO shape
`define CMP_FIFO_WIDTH    16
`define CMP_FIFO_DEPTH    8

`endif

// File: core/cmp_pkg.sv
// Types shared by the control math block
package cmp_pkg;

    // Sample step sequencer states
    typedef enum logic [1:0] {
        CMP_IDLE,
        CMP_LOAD,
        CMP_ROTATE,
        CMP_COMMIT
    } cmp_state_t;

endpackage

// File: core/cmp_fifo.sv
// Parameterised valid/ready FIFO for incoming filter samples
`timescale 1ns/1ps
module cmp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire logic                      inValid,
    output logic                           inReady,
    input  wire logic [WIDTH-1:0]          inData,
    output logic                           outValid,
    input  wire logic                      outReady,
    output logic [WIDTH-1:0]               outData,
    output logic [$clog2(DEPTH+1)-1:0]     count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];         // Storage words
    logic [AW-1:0]    wrPtr_q;             // Next slot to fill
    logic [AW-1:0]    rdPtr_q;             // Next slot to drain
    logic [CW-1:0]    count_q;             // Words held
    logic             push;                // Accepted write
    logic             pop;                 // Accepted read

    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign inReady  = (count_q != CW'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];
    assign count    = count_q;

    // Storage write, no reset needed on data
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Pointers wrap explicitly so depth need not be a power of two
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
            end
        end
    end

    // Occupancy tracks push and pop together
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (push && !pop) begin
            count_q <= count_q + 1'b1;
        end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
        end
    end

endmodule

// File: core/cmp_math_top.sv
// Control math primitives: high-pass, vector rotator, inverse 3-to-2 phase, clamp, APB slave
//
// Overview of operation
// - High-pass: saturate input minus previous output
// - Multiply by cutoff gain, shift left three
// - Enabled: saturating integrate; disabled: clear integrator
// - Output is input minus integrator upper half
// - Enable low forces high-pass output zero
// - Rotator rotates input pair, gain 1.64676
// - Angle 4096 counts equals one full turn
// - Inputs d/q, outputs alpha/beta
// - Transform first output equals first phase
// - Second: (V-W)*2365 >>11, bits 12:1
// - Clamp passes input, else reached threshold
// - Saturation flags mark output equal threshold
// - Upper below lower: lower out, lower flag
// - Equal thresholds: lower out, both flags
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "cmp_defs.svh"
module cmp_math_top
    import cmp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [15:0] hpOut,
    output logic      [15:0] alphaOut,
    output logic      [15:0] betaOut,
    output logic      [15:0] phaseAOut,
    output logic      [15:0] phaseBOut,
    output logic      [15:0] clampOut,
    output logic             upper_saturation_flag,
    output logic             lower_saturation_flag,
    output logic             stepDone
);

    // Software-written operands
    logic               hpEnable_q;        // High-pass enable
    logic        [15:0] cutoff_gain_q;     // Unsigned cutoff gain
    logic signed [15:0] rotD_q;            // Direct-axis input
    logic signed [15:0] rotQ_q;            // Quadrature-axis input
    logic        [15:0] theta_q;           // Angle, 4096 per turn
    logic signed [15:0] phU_q;             // Phase inputs
    logic signed [15:0] phV_q;
    logic signed [15:0] phW_q;
    logic signed [15:0] clIn_q;            // Clamp input
    logic signed [15:0] clUp_q;            // Upper threshold
    logic signed [15:0] clLo_q;            // Lower threshold

    // Recursive state and results
    logic signed [31:0] integ_q;           // High-pass integrator
    logic signed [15:0] hpOut_q;           // Previous high-pass output
    logic signed [15:0] alpha_q;
    logic signed [15:0] beta_q;
    logic signed [15:0] phA_q;
    logic signed [15:0] phB_q;
    logic signed [15:0] clOut_q;
    logic               upper_saturation_flag_q;
    logic               lower_saturation_flag_q;
    logic               stepDone_q;
    logic        [15:0] stepCount_q;       // Completed steps

    // Bus slave state
    logic        [31:0] prdata_q;
    logic               pready_q;
    logic               pslverr_q;

    // Sequencer and rotator datapath
    cmp_state_t         state_q;
    logic        [3:0]  iter_q;            // Rotation iteration index
    logic signed [17:0] rx_q;              // Rotator x accumulator
    logic signed [17:0] ry_q;              // Rotator y accumulator
    logic signed [15:0] rz_q;              // Residual angle, 65536 per turn
    logic signed [15:0] sample_q;          // Sample being processed

    // FIFO wiring
    logic               fifoInValid;
    logic               fifoInReady;
    logic        [15:0] fifoOutData;
    logic               fifoOutValid;
    logic               fifoOutReady;
    logic        [3:0]  fifoCount;

    // Bus decode
    logic               accessPhase;
    logic               commit;
    logic               sampleWrite;
    logic               addrMapped;

    assign accessPhase = psel && penable;
    assign commit      = accessPhase && pready_q;
    assign sampleWrite = pwrite && (paddr == `CMP_REG_SAMPLE);

    // Writes to the sample port are committed only once the FIFO has room
    assign fifoInValid  = commit && sampleWrite && !pslverr_q;
    assign fifoOutReady = (state_q == CMP_IDLE);

    cmp_fifo #(
        .WIDTH (`CMP_FIFO_WIDTH),
        .DEPTH (`CMP_FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (pwdata[15:0]),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData),
        .count    (fifoCount)
    );

    // Address map check
    always_comb begin
        case (paddr)
            `CMP_REG_CTRL, `CMP_REG_SAMPLE, `CMP_REG_GAIN, `CMP_REG_ROT_D,
            `CMP_REG_ROT_Q, `CMP_REG_THETA, `CMP_REG_PH_U, `CMP_REG_PH_V,
            `CMP_REG_PH_W, `CMP_REG_CL_IN, `CMP_REG_CL_UP, `CMP_REG_CL_LO,
            `CMP_REG_HP_OUT, `CMP_REG_ROT_OUT, `CMP_REG_CLK_OUT,
            `CMP_REG_CL_OUT, `CMP_REG_STATUS: addrMapped = 1'b1;
            default:                          addrMapped = 1'b0;
        endcase
    end

    // Read mux, sampled into prdata when the answer is raised
    logic [31:0] readValue;
    always_comb begin
        readValue = `CMP_RST_W32;
        case (paddr)
            `CMP_REG_CTRL:    readValue = {31'h0, hpEnable_q};
            `CMP_REG_GAIN:    readValue = {16'h0, cutoff_gain_q};
            `CMP_REG_ROT_D:   readValue = {16'h0, rotD_q};
            `CMP_REG_ROT_Q:   readValue = {16'h0, rotQ_q};
            `CMP_REG_THETA:   readValue = {16'h0, theta_q};
            `CMP_REG_PH_U:    readValue = {16'h0, phU_q};
            `CMP_REG_PH_V:    readValue = {16'h0, phV_q};
            `CMP_REG_PH_W:    readValue = {16'h0, phW_q};
            `CMP_REG_CL_IN:   readValue = {16'h0, clIn_q};
            `CMP_REG_CL_UP:   readValue = {16'h0, clUp_q};
            `CMP_REG_CL_LO:   readValue = {16'h0, clLo_q};
            `CMP_REG_HP_OUT:  readValue = {16'h0, hpOut_q};
            `CMP_REG_ROT_OUT: readValue = {beta_q, alpha_q};
            `CMP_REG_CLK_OUT: readValue = {phB_q, phA_q};
            `CMP_REG_CL_OUT:  readValue = {14'h0, lower_saturation_flag_q, upper_saturation_flag_q, clOut_q};
            `CMP_REG_STATUS:  readValue = {stepCount_q, 11'h0, fifoCount,
                                           (state_q != CMP_IDLE)};
            default:          readValue = `CMP_RST_W32;
        endcase
    end

    // Answer after one wait cycle; a sample write to a full FIFO waits for space,
    // which is how back-pressure reaches the bus master
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= `CMP_RST_W32;
        end else if (commit) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (accessPhase && (!sampleWrite || fifoInReady)) begin
            pready_q  <= 1'b1;
            pslverr_q <= !addrMapped;
            prdata_q  <= pwrite ? `CMP_RST_W32 : readValue;
        end
    end

    // Operand registers take effect at the committing edge
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hpEnable_q    <= 1'b0;
            cutoff_gain_q <= `CMP_RST_W16;
            rotD_q        <= `CMP_RST_W16;
            rotQ_q        <= `CMP_RST_W16;
            theta_q       <= `CMP_RST_W16;
            phU_q         <= `CMP_RST_W16;
            phV_q         <= `CMP_RST_W16;
            phW_q         <= `CMP_RST_W16;
            clIn_q        <= `CMP_RST_W16;
            clUp_q        <= `CMP_RST_W16;
            clLo_q        <= `CMP_RST_W16;
        end else if (commit && pwrite) begin
            case (paddr)
                `CMP_REG_CTRL:  hpEnable_q    <= pwdata[`CMP_CTRL_EN_BIT];
                `CMP_REG_GAIN:  cutoff_gain_q <= pwdata[15:0];
                `CMP_REG_ROT_D: rotD_q        <= pwdata[15:0];
                `CMP_REG_ROT_Q: rotQ_q        <= pwdata[15:0];
                `CMP_REG_THETA: theta_q       <= pwdata[15:0];
                `CMP_REG_PH_U:  phU_q         <= pwdata[15:0];
                `CMP_REG_PH_V:  phV_q         <= pwdata[15:0];
                `CMP_REG_PH_W:  phW_q         <= pwdata[15:0];
                `CMP_REG_CL_IN: clIn_q        <= pwdata[15:0];
                `CMP_REG_CL_UP: clUp_q        <= pwdata[15:0];
                `CMP_REG_CL_LO: clLo_q        <= pwdata[15:0];
                default:        ;
            endcase
        end
    end

    // Saturate a 17-bit signed value to 16 bits
    function automatic logic signed [15:0] sat16(input logic signed [16:0] v);
        if (v > 17'sh07fff) begin
            sat16 = 16'sh7fff;
        end else if (v < -17'sh08000) begin
            sat16 = 16'sh8000;
        end else begin
            sat16 = v[15:0];
        end
    endfunction

    // Arc tangent of 2^-i in units of 1/65536 turn
    function automatic logic signed [15:0] atanStep(input logic [3:0] i);
        case (i)
            4'h0:    atanStep = 16'sh2000;
            4'h1:    atanStep = 16'sh12e4;
            4'h2:    atanStep = 16'sh09fb;
            4'h3:    atanStep = 16'sh0511;
            4'h4:    atanStep = 16'sh028b;
            4'h5:    atanStep = 16'sh0146;
            4'h6:    atanStep = 16'sh00a3;
            4'h7:    atanStep = 16'sh0051;
            4'h8:    atanStep = 16'sh0029;
            4'h9:    atanStep = 16'sh0014;
            4'ha:    atanStep = 16'sh000a;
            4'hb:    atanStep = 16'sh0005;
            4'hc:    atanStep = 16'sh0003;
            default: atanStep = 16'sh0001;
        endcase
    endfunction

    // High-pass arithmetic for the sample in hand
    logic signed [15:0] hpDiff;
    logic signed [32:0] hpProd;
    logic signed [31:0] hpShifted;
    logic signed [32:0] hpSum;
    logic signed [31:0] hpInteg;
    logic signed [15:0] hpNext;
    always_comb begin
        hpDiff    = sat16(17'(sample_q) - 17'(hpOut_q));
        hpProd    = $signed(33'(hpDiff)) * $signed({17'h0, cutoff_gain_q});
        hpShifted = {hpProd[28:0], 3'h0};
        hpSum     = 33'(integ_q) + 33'(hpShifted);
        if (hpSum > 33'sh0_7fff_ffff) begin
            hpInteg = 32'sh7fff_ffff;
        end else if (hpSum < -33'sh0_8000_0000) begin
            hpInteg = 32'sh8000_0000;
        end else begin
            hpInteg = hpSum[31:0];
        end
        hpNext = sat16(17'(sample_q) - 17'($signed(hpInteg[31:16])));
    end

    // Inverse 3-to-2 phase arithmetic
    logic signed [16:0] clkDiff;
    logic signed [33:0] clkProd;
    logic signed [33:0] clkShift;
    always_comb begin
        clkDiff  = 17'(phV_q) - 17'(phW_q);
        clkProd  = 34'(clkDiff) * 34'(`CMP_CLARK_GAIN);
        clkShift = clkProd >>> `CMP_CLARK_SHIFT;
    end

    // Clamp with degenerate threshold handling
    logic signed [15:0] clNext;
    logic               satPNext;
    logic               satMNext;
    always_comb begin
        if (clUp_q <= clLo_q) begin
            clNext   = clLo_q;
            satPNext = (clUp_q == clLo_q);
            satMNext = 1'b1;
        end else begin
            clNext = clIn_q;
            if (clIn_q >= clUp_q) begin
                clNext = clUp_q;
            end
            if (clIn_q <= clLo_q) begin
                clNext = clLo_q;
            end
            satPNext = (clNext == clUp_q);
            satMNext = (clNext == clLo_q);
        end
    end

    // Rotator stage: angle scaled to 65536 per turn so the residual wraps naturally
    logic signed [15:0] zStart;
    logic               flipHalf;
    assign zStart   = theta_q << `CMP_THETA_SHIFT;
    assign flipHalf = (zStart[15] != zStart[14]);

    // Step sequencer: one FIFO sample starts one step
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q  <= CMP_IDLE;
            iter_q   <= 4'h0;
            sample_q <= `CMP_RST_W16;
        end else begin
            case (state_q)
                CMP_IDLE: begin
                    if (fifoOutValid) begin
                        sample_q <= fifoOutData;
                        state_q  <= CMP_LOAD;
                    end
                end
                CMP_LOAD: begin
                    iter_q  <= 4'h0;
                    state_q <= CMP_ROTATE;
                end
                CMP_ROTATE: begin
                    iter_q <= iter_q + 4'h1;
                    if (iter_q == 4'(`CMP_ROT_ITERS - 1)) begin
                        state_q <= CMP_COMMIT;
                    end
                end
                CMP_COMMIT: state_q <= CMP_IDLE;
                default:    state_q <= CMP_IDLE;
            endcase
        end
    end

    // Shift-add rotation; its inherent gain of 1.64676 is the required scaling
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_q <= 18'sh0;
            ry_q <= 18'sh0;
            rz_q <= `CMP_RST_W16;
        end else if (state_q == CMP_LOAD) begin
            // Half-turn pre-rotation keeps the residual inside convergence
            rx_q <= flipHalf ? -18'(rotD_q) : 18'(rotD_q);
            ry_q <= flipHalf ? -18'(rotQ_q) : 18'(rotQ_q);
            rz_q <= flipHalf ? zStart - `CMP_HALF_TURN : zStart;
        end else if (state_q == CMP_ROTATE) begin
            if (rz_q >= 0) begin
                rx_q <= rx_q - (ry_q >>> iter_q);
                ry_q <= ry_q + (rx_q >>> iter_q);
                rz_q <= rz_q - atanStep(iter_q);
            end else begin
                rx_q <= rx_q + (ry_q >>> iter_q);
                ry_q <= ry_q - (rx_q >>> iter_q);
                rz_q <= rz_q + atanStep(iter_q);
            end
        end
    end

    // High-pass state; a low enable clears output and integrator at once
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            integ_q <= `CMP_RST_W32;
            hpOut_q <= `CMP_RST_W16;
        end else if (!hpEnable_q) begin
            integ_q <= `CMP_RST_W32;
            hpOut_q <= `CMP_RST_W16;
        end else if (state_q == CMP_COMMIT) begin
            integ_q <= hpInteg;
            hpOut_q <= hpNext;
        end
    end

    // All other stage results update together at the end of the step
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            alpha_q <= `CMP_RST_W16;
            beta_q  <= `CMP_RST_W16;
            phA_q   <= `CMP_RST_W16;
            phB_q   <= `CMP_RST_W16;
            clOut_q <= `CMP_RST_W16;
            upper_saturation_flag_q  <= 1'b0;
            lower_saturation_flag_q  <= 1'b0;
        end else if (state_q == CMP_COMMIT) begin
            alpha_q <= rx_q[15:0];
            beta_q  <= ry_q[15:0];
            phA_q   <= phU_q;
            phB_q   <= {{4{clkShift[12]}}, clkShift[12:1]};
            clOut_q <= clNext;
            upper_saturation_flag_q  <= satPNext;
            lower_saturation_flag_q  <= satMNext;
        end
    end

    // Step completion pulse and counter
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stepDone_q  <= 1'b0;
            stepCount_q <= `CMP_RST_W16;
        end else begin
            stepDone_q <= (state_q == CMP_COMMIT);
            if (state_q == CMP_COMMIT) begin
                stepCount_q <= stepCount_q + 16'h0001;
            end
        end
    end

    // Every output straight from a flip-flop
    assign prdata                = prdata_q;
    assign pready                = pready_q;
    assign pslverr               = pslverr_q;
    assign hpOut                 = hpOut_q;
    assign alphaOut              = alpha_q;
    assign betaOut               = beta_q;
    assign phaseAOut             = phA_q;
    assign phaseBOut             = phB_q;
    assign clampOut              = clOut_q;
    assign upper_saturation_flag = upper_saturation_flag_q;
    assign lower_saturation_flag = lower_saturation_flag_q;
    assign stepDone              = stepDone_q;

endmodule

// File: verif/cmp_math_sva.sv
// Checker of step-aligned outputs and bus timing of the math block
`timescale 1ns/1ps
module cmp_math_sva (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] alphaOut,
    input wire logic [15:0] phaseBOut,
    input wire logic [15:0] clampOut,
    input wire logic        upper_saturation_flag,
    input wire logic        stepDone
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // First access cycle; sample pushes may stall on a full queue, so they are left out
    sequence sAccessStart;
        psel && penable && !$past(penable) && !(pwrite && paddr == 8'h04);
    endsequence
    sequence sOneBeat;
        pready ##1 !pready;
    endsequence
    // Results other than the high-pass output may only move at a step commit, so stepDone must be high in the same cycle
    AST_CLAMP_STEP: assert property (!$stable(clampOut) |-> stepDone)
        else $error("clamp output moved outside a step");
    AST_ROT_STEP: assert property (!$stable(alphaOut) |-> stepDone)
        else $error("rotator output moved outside a step");
    AST_PHASE_STEP: assert property (!$stable(phaseBOut) |-> stepDone)
        else $error("phase output moved outside a step");
    AST_FLAG_STEP: assert property (!$stable(upper_saturation_flag) |-> stepDone)
        else $error("saturation flag moved outside a step");
    AST_DONE_PULSE: assert property (stepDone |=> !stepDone)
        else $error("step done longer than one cycle");
    AST_WAIT_STATE: assert property (sAccessStart |-> !pready ##1 sOneBeat)
        else $error("bus answer not after one wait state");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_READY_SEL: assert property (pready |-> $past(psel && penable))
        else $error("ready without an access");
endmodule
bind cmp_math_top cmp_math_sva u_sva (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pready, .pslverr, .alphaOut, .phaseBOut, .clampOut, .upper_saturation_flag, .stepDone);

// File: verif/cmp_partner.sv
// Downstream compute block model: takes the clamp result at each step end
`timescale 1ns/1ps
module cmp_partner (
    input wire logic        core_clk,
    input wire logic        stepDone,
    input wire logic [15:0] clampOut,
    output logic     [15:0] heldClamp
);
    // Latch once per step so the consumer never sees a half-updated set
    always_ff @(posedge core_clk) begin
        if (stepDone) begin
            heldClamp <= clampOut;
        end
    end
endmodule

// File: verif/tb.sv
// Self-checking bench of the control math block over the register bus
`timescale 1ns/1ps
`include "cmp_defs.svh"
module tb;
    logic               core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0, prdata, rdat;
    logic               pready, pslverr, err, stepDone, upF, loF;
    logic [15:0]        hpOut, alphaOut, betaOut, phaseAOut, phaseBOut, clampOut, heldClamp;
    logic signed [15:0] hpPrev, dif;
    logic signed [31:0] acc;
    int                 num_errors = 0, samples_checked = 0, cyc = 0;
    cmp_math_top DUT (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .hpOut, .alphaOut, .betaOut, .phaseAOut, .phaseBOut, .clampOut,
        .upper_saturation_flag(upF), .lower_saturation_flag(loF), .stepDone);
    cmp_partner u_partner (.core_clk, .stepDone, .clampOut, .heldClamp);
    initial forever #2 core_clk = ~core_clk;
    // Hang guard: a full run needs well under this many cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // One transfer; the request is held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // Push a sample and wait, bounded, for its step to commit
    task automatic step(input logic [15:0] x);
        apb(1, `CMP_REG_SAMPLE, {16'h0, x});
        repeat (100) begin
            @(negedge core_clk);
            if (stepDone === 1'b1) break;
        end
    endtask
    function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
        return (v > 34'sd32767) ? 16'sh7fff : (v < -34'sd32768) ? 16'sh8000 : v[15:0];
    endfunction
    task automatic test_clamp();
        logic [15:0] t [6][6] = '{'{16'h0064, 16'h00c8, 16'hff38, 16'h0064, 16'h0, 16'h0},
            '{16'h012c, 16'h00c8, 16'hff38, 16'h00c8, 16'h1, 16'h0},
            '{16'hfed4, 16'h00c8, 16'hff38, 16'hff38, 16'h0, 16'h1},
            '{16'hff38, 16'h00c8, 16'hff38, 16'hff38, 16'h0, 16'h1},
            '{16'h0005, 16'hfff6, 16'h000a, 16'h000a, 16'h0, 16'h1},
            '{16'h0005, 16'h0007, 16'h0007, 16'h0007, 16'h1, 16'h1}};
        for (int i = 0; i < 6; i++) begin
            apb(1, `CMP_REG_CL_IN, {16'h0, t[i][0]});
            apb(1, `CMP_REG_CL_UP, {16'h0, t[i][1]});
            apb(1, `CMP_REG_CL_LO, {16'h0, t[i][2]});
            step(16'h0);
            check({upF, loF, clampOut}, {t[i][4][0], t[i][5][0], t[i][3]});
        end
        @(negedge core_clk);
        check(heldClamp, 16'h0007);
    endtask
    task automatic test_clark(input logic signed [15:0] u, v, w);
        logic signed [31:0] p;
        p = ((32'(v) - 32'(w)) * 2365) >>> 11;
        apb(1, `CMP_REG_PH_U, 32'(u));
        apb(1, `CMP_REG_PH_V, 32'(v));
        apb(1, `CMP_REG_PH_W, 32'(w));
        step(16'h0);
        check({phaseAOut, phaseBOut}, {u, {4{p[12]}}, p[12:1]});
    endtask
    task automatic near(input logic [15:0] s, input logic signed [15:0] e);
        check(($signed(s) - e <= 3 && e - $signed(s) <= 3) ? 32'(e) : 32'(s), 32'(e));
    endtask
    task automatic test_rot(input logic [15:0] d, q, th, input logic signed [15:0] a, b);
        apb(1, `CMP_REG_ROT_D, {16'h0, d});
        apb(1, `CMP_REG_ROT_Q, {16'h0, q});
        apb(1, `CMP_REG_THETA, {16'h0, th});
        step(16'h0);
        near(alphaOut, a);
        near(betaOut, b);
    endtask
    // Filter with a live gain, then disable, then zero-gain pass-through queueing nine samples
    task automatic test_hp();
        logic signed [15:0] xs [3] = '{16'sh1b58, 16'sh8ad0, 16'sh04d2};
        apb(1, `CMP_REG_GAIN, 32'h1000);
        apb(1, `CMP_REG_CTRL, 32'h1);
        hpPrev = 0; acc = 0;
        foreach (xs[i]) begin
            dif = sat16(34'(xs[i]) - hpPrev);
            acc = (34'(acc) + 34'((32'(dif) * 32'sh1000) <<< 3) > 34'sh7fffffff) ? 32'sh7fffffff
                : acc + ((32'(dif) * 32'sh1000) <<< 3);
            hpPrev = sat16(34'(xs[i]) - $signed(acc[31:16]));
            step(xs[i]);
            check($signed(hpOut), hpPrev);
        end
        apb(1, `CMP_REG_CTRL, 32'h0);
        repeat (2) @(negedge core_clk);
        check(hpOut, 16'h0);
        apb(1, `CMP_REG_GAIN, 32'h0);
        apb(1, `CMP_REG_CTRL, 32'h1);
        for (int i = 1; i < 10; i++) apb(1, `CMP_REG_SAMPLE, 32'(i * 16'h0111));
        repeat (200) begin
            apb(0, `CMP_REG_STATUS, 32'h0);
            if (rdat[4:0] === 5'h00) break;
        end
        check(hpOut, 16'h0999);
        apb(0, 8'h44, 32'h0);
        check(rdat, 32'h0);
        check({31'h0, err}, 32'h1);
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1;
        test_clamp();
        test_clark(16'sd100, 16'sd1000, -16'sd500);
        test_clark(-16'sd4096, -16'sd1000, 16'sd2000);
        test_rot(16'd1000, 16'd0, 16'd1024, 16'sd0, 16'sd1647);
        test_rot(16'hf000, 16'h1000, 16'd0, -16'sd6745, 16'sd6745);
        test_rot(16'd1000, 16'd300, 16'd2048, -16'sd1647, -16'sd494);
        test_hp();
        complete_run();
    end
endmodule
